// ---- src/pmx_pkg.sv ----
// Purpose: shared constants and types for the port pin-function select block
// Assumes: 16-bit register bus; four ports of eight pins each
// Notes:   offsets are byte addresses on the plain register port
`default_nettype none

package pmx_pkg;

  // ==========================================================================
  // geometry
  localparam int unsigned NUM_PORTS  = 4;
  localparam int unsigned PINS       = 8;
  localparam int unsigned DATA_W     = 16;
  localparam int unsigned ADDR_W     = 4;
  localparam int unsigned FIELD_W    = 2;

  // ==========================================================================
  // port indices, in register order
  localparam int unsigned PORT_H = 0;
  localparam int unsigned PORT_J = 1;
  localparam int unsigned PORT_K = 2;
  localparam int unsigned PORT_L = 3;

  // ==========================================================================
  // register byte offsets
  localparam logic [ADDR_W-1:0] PORT_H_OFS = 4'h0;
  localparam logic [ADDR_W-1:0] PORT_J_OFS = 4'h2;
  localparam logic [ADDR_W-1:0] PORT_K_OFS = 4'h4;
  localparam logic [ADDR_W-1:0] PORT_L_OFS = 4'h6;

  // ==========================================================================
  // power-on reset values
  localparam logic [DATA_W-1:0] PORT_H_RST_STRAP_HI = 16'hAAAA;
  localparam logic [DATA_W-1:0] PORT_H_RST_STRAP_LO = 16'h8AAA;
  localparam logic [DATA_W-1:0] PORT_J_RST          = 16'h0000;
  localparam logic [DATA_W-1:0] PORT_K_RST          = 16'h0000;
  localparam logic [DATA_W-1:0] PORT_L_RST          = 16'h0000;
  localparam logic [DATA_W-1:0] READ_UNMAPPED       = 16'h0000;

  // ==========================================================================
  // per-pin capability masks, bit n for pin n
  localparam logic [PINS-1:0] PORT_H_PERIPH = 8'hFF;
  localparam logic [PINS-1:0] PORT_H_OUTPUT = 8'h80;
  localparam logic [PINS-1:0] PORT_J_PERIPH = 8'hCD;
  localparam logic [PINS-1:0] PORT_J_OUTPUT = 8'hFF;
  localparam logic [PINS-1:0] PORT_K_PERIPH = 8'hFF;
  localparam logic [PINS-1:0] PORT_K_OUTPUT = 8'hFF;
  localparam logic [PINS-1:0] PORT_L_PERIPH = 8'hFF;
  localparam logic [PINS-1:0] PORT_L_OUTPUT = 8'h00;

  // ==========================================================================
  // field codes
  localparam logic [FIELD_W-1:0] CODE_PERIPH  = 2'h0;
  localparam logic [FIELD_W-1:0] CODE_OUTPUT  = 2'h1;
  localparam logic [FIELD_W-1:0] CODE_IN_PULL = 2'h2;
  localparam logic [FIELD_W-1:0] CODE_IN_FREE = 2'h3;

  // effective pin mode, one-hot
  typedef enum logic [3:0] {
    PMX_PERIPH  = 4'h1,
    PMX_OUTPUT  = 4'h2,
    PMX_IN_PULL = 4'h4,
    PMX_IN_FREE = 4'h8
  } pmxMode_t;

  // control handed to one pin's pad and function mux
  typedef struct packed {
    logic     periphSel;   // peripheral owns the pin
    logic     portOe_n;    // low while the port data register drives the pin
    logic     pullUpEn;    // pull-up switched on
    logic     reserved;    // field holds a reserved code
    pmxMode_t mode;
  } pmxPinCtl_t;

  // register bus request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } pmxBusReq_t;

endpackage

`default_nettype wire

// ---- src/pmx_pin_decode.sv ----
// Purpose: turns one pin's two-bit select field into pad control
// Assumes: capability flags are constants per pin
// Notes:   purely combinational
`default_nettype none

module pmx_pin_decode (
  // field and capabilities
  input  wire logic [pmx_pkg::FIELD_W-1:0] field,
  input  wire logic                        canPeriph,
  input  wire logic                        canOutput,
  // pad control
  output var  pmx_pkg::pmxPinCtl_t         ctl
);

  // ==========================================================================
  // decode
  wire logic highBit     = field[1];
  wire logic lowBit      = field[0];
  wire logic isPeriph    = (field == pmx_pkg::CODE_PERIPH) && canPeriph;
  wire logic isOutput    = (field == pmx_pkg::CODE_OUTPUT) && canOutput;
  wire logic isReserved  = !highBit && !isPeriph && !isOutput;
  // reserved codes fall back to a floating input: no drive, no pull
  wire logic pullOn      = highBit && !lowBit;

  always_comb begin
    ctl.periphSel = isPeriph;
    ctl.portOe_n  = !isOutput;
    ctl.pullUpEn  = pullOn;
    ctl.reserved  = isReserved;
    case (1'b1)
      isPeriph: ctl.mode = pmx_pkg::PMX_PERIPH;
      isOutput: ctl.mode = pmx_pkg::PMX_OUTPUT;
      pullOn:   ctl.mode = pmx_pkg::PMX_IN_PULL;
      default:  ctl.mode = pmx_pkg::PMX_IN_FREE;
    endcase
  end

endmodule

`default_nettype wire

// ---- src/pmx_pin_select.sv ----
// Purpose: pin-function select registers for ports H, J, K and L
// Assumes: rst_n is the power-on reset; manual reset, standby and sleep
//          never reach this block
// Notes:   registers are read back exactly as written, reserved codes too
//
// Summary of operation
// - four 16-bit read/write registers; pin n uses bits 2n+1 and 2n
// - port H resets to AAAA with strap high, 8AAA with strap low
// - only power-on reset reloads; manual reset, standby, sleep keep contents
// - port H pin 7: peripheral, output, pulled input, unpulled input
// - port H pin 6: peripheral, reserved, pulled input, unpulled input
// - port H pins 5..0: peripheral, reserved, pulled and unpulled input
// - high bit set makes pin an input, pulled only when low bit clear
// - port J clears to 0000 at power-on reset
// - port J code 00 reserved on pins 1, 4, 5; otherwise full choice
// - port K clears to 0000 at power-on reset
// - port K pins: peripheral, output, pulled input, unpulled input
// - port L clears to 0000 at power-on reset
// - port L pins: peripheral, reserved, pulled input, unpulled input
// - strap sampled during reset, becomes general input after release
//
// Added by the designer: the address-and-strobe port and the placing of the registers.
`default_nettype none

module pmx_pin_select (
  // clock and power-on reset
  input  wire logic                             clk,
  input  wire logic                             rst_n,
  // register port
  input  wire logic [pmx_pkg::ADDR_W-1:0]       addr,
  input  wire logic [pmx_pkg::DATA_W-1:0]       wdata,
  input  wire logic                             wr,
  input  wire logic                             rd,
  output var  logic [pmx_pkg::DATA_W-1:0]       rdata,
  // mode strap pin
  input  wire logic                             emulatorModeStrap,
  output var  logic                             strapPortIn,
  // pad control, index port*8+pin
  output var  pmx_pkg::pmxPinCtl_t [31:0]       pinCtl
);

  localparam int unsigned NP = pmx_pkg::NUM_PORTS;
  localparam int unsigned NB = pmx_pkg::PINS;

  // ==========================================================================
  // bus request bundle
  pmx_pkg::pmxBusReq_t req;
  assign req.addr  = addr;
  assign req.wdata = wdata;
  assign req.wr    = wr;
  assign req.rd    = rd;

  // ==========================================================================
  // strap synchroniser
  // no reset here: the strap must be seen while reset is held
  logic strapMeta_q;
  logic strapSync_q;
  logic runPhase_q;
  logic strapIn_q;

  always_ff @(posedge clk) begin
    strapMeta_q <= emulatorModeStrap;
    strapSync_q <= strapMeta_q;
  end

  // after release the pin is an ordinary port input
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      runPhase_q <= 1'b0;
      strapIn_q  <= 1'b0;
    end else begin
      runPhase_q <= 1'b1;
      strapIn_q  <= strapSync_q;
    end
  end

  assign strapPortIn = strapIn_q;

  // ==========================================================================
  // address decode
  wire logic [NP-1:0] hit;
  assign hit[pmx_pkg::PORT_H] = (req.addr == pmx_pkg::PORT_H_OFS);
  assign hit[pmx_pkg::PORT_J] = (req.addr == pmx_pkg::PORT_J_OFS);
  assign hit[pmx_pkg::PORT_K] = (req.addr == pmx_pkg::PORT_K_OFS);
  assign hit[pmx_pkg::PORT_L] = (req.addr == pmx_pkg::PORT_L_OFS);

  // ==========================================================================
  // reset values and capability tables
  wire logic [pmx_pkg::DATA_W-1:0] rstVal [NP];
  wire logic [NB-1:0]              capPeriph [NP];
  wire logic [NB-1:0]              capOutput [NP];

  // port H value follows the strap level seen during reset
  assign rstVal[pmx_pkg::PORT_H] = strapSync_q ?
                                   pmx_pkg::PORT_H_RST_STRAP_HI :
                                   pmx_pkg::PORT_H_RST_STRAP_LO;
  assign rstVal[pmx_pkg::PORT_J] = pmx_pkg::PORT_J_RST;
  assign rstVal[pmx_pkg::PORT_K] = pmx_pkg::PORT_K_RST;
  assign rstVal[pmx_pkg::PORT_L] = pmx_pkg::PORT_L_RST;

  // pin 7 alone has port output on H; pins 6..0 decode codes 01 as reserved
  assign capPeriph[pmx_pkg::PORT_H] = pmx_pkg::PORT_H_PERIPH;
  assign capOutput[pmx_pkg::PORT_H] = pmx_pkg::PORT_H_OUTPUT;
  assign capPeriph[pmx_pkg::PORT_J] = pmx_pkg::PORT_J_PERIPH;
  assign capOutput[pmx_pkg::PORT_J] = pmx_pkg::PORT_J_OUTPUT;
  assign capPeriph[pmx_pkg::PORT_K] = pmx_pkg::PORT_K_PERIPH;
  assign capOutput[pmx_pkg::PORT_K] = pmx_pkg::PORT_K_OUTPUT;
  assign capPeriph[pmx_pkg::PORT_L] = pmx_pkg::PORT_L_PERIPH;
  assign capOutput[pmx_pkg::PORT_L] = pmx_pkg::PORT_L_OUTPUT;

  // ==========================================================================
  // select registers
  logic [pmx_pkg::DATA_W-1:0] sel_q [NP];

  genvar p;
  genvar b;
  generate
    for (p = 0; p < NP; p++) begin : g_port
      wire logic [pmx_pkg::DATA_W-1:0] sel_d;
      // full 16-bit write; reserved codes are kept as written
      assign sel_d = (req.wr && hit[p]) ? req.wdata : sel_q[p];

      // only the power-on reset reloads; nothing else touches these
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          sel_q[p] <= rstVal[p];
        end else begin
          sel_q[p] <= sel_d;
        end
      end

      for (b = 0; b < NB; b++) begin : g_pin
        pmx_pkg::pmxPinCtl_t ctl;
        pmx_pin_decode u_dec (
          .field     (sel_q[p][2*b+1:2*b]),
          .canPeriph (capPeriph[p][b]),
          .canOutput (capOutput[p][b]),
          .ctl       (ctl)
        );
        // pads stay as floating inputs until the strap has been taken
        always_ff @(posedge clk) begin
          if (!rst_n) begin
            pinCtl[p*NB+b].periphSel <= 1'b0;
            pinCtl[p*NB+b].portOe_n  <= 1'b1;
            pinCtl[p*NB+b].pullUpEn  <= 1'b0;
            pinCtl[p*NB+b].reserved  <= 1'b0;
            pinCtl[p*NB+b].mode      <= pmx_pkg::PMX_IN_FREE;
          end else if (runPhase_q) begin
            pinCtl[p*NB+b] <= ctl;
          end
        end
      end
    end
  endgenerate

  // ==========================================================================
  // read path, one cycle after the strobe
  wire logic [pmx_pkg::DATA_W-1:0] rdSel;
  assign rdSel = hit[pmx_pkg::PORT_H] ? sel_q[pmx_pkg::PORT_H] :
                 hit[pmx_pkg::PORT_J] ? sel_q[pmx_pkg::PORT_J] :
                 hit[pmx_pkg::PORT_K] ? sel_q[pmx_pkg::PORT_K] :
                 hit[pmx_pkg::PORT_L] ? sel_q[pmx_pkg::PORT_L] :
                 pmx_pkg::READ_UNMAPPED;

  logic [pmx_pkg::DATA_W-1:0] rdata_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_q <= pmx_pkg::READ_UNMAPPED;
    end else if (req.rd) begin
      rdata_q <= rdSel;
    end else begin
      rdata_q <= pmx_pkg::READ_UNMAPPED;
    end
  end

  assign rdata = rdata_q;

endmodule

`default_nettype wire

// ---- tb/pmx_pin_select_sva.sv ----
// Purpose: port-level assertions for pmx_pin_select
// Assumes: one clock; rst_n synchronous, active low
// Notes:   pad control lags a write strobe by two edges
`default_nettype none

module pmx_pin_select_sva (
  // clock and reset
  input wire logic                       clk,
  input wire logic                       rst_n,
  // register port
  input wire logic [pmx_pkg::ADDR_W-1:0] addr,
  input wire logic [pmx_pkg::DATA_W-1:0] wdata,
  input wire logic                       wr,
  input wire logic                       rd,
  input wire logic [pmx_pkg::DATA_W-1:0] rdata,
  // strap and pads
  input wire logic                       emulatorModeStrap,
  input wire logic                       strapPortIn,
  input wire pmx_pkg::pmxPinCtl_t [31:0] pinCtl
);
  timeunit 1ns;
  timeprecision 1ns;

  wire logic wrH = wr && addr == pmx_pkg::PORT_H_OFS;
  wire logic wrJ = wr && addr == pmx_pkg::PORT_J_OFS;
  wire logic wrK = wr && addr == pmx_pkg::PORT_K_OFS;
  wire logic wrL = wr && addr == pmx_pkg::PORT_L_OFS;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ==========
  // checks
  read_back_a: assert property (
    wrK ##1 (rd && addr == pmx_pkg::PORT_K_OFS) |=> rdata == $past(wdata, 2))
    else $error("read after write lost data");
  rdata_idle_a: assert property (!rd |=> rdata == 16'h0000)
    else $error("read data outside read slot");
  unmapped_rd_a: assert property (
    rd && (addr[0] || addr[3]) |=> rdata == 16'h0000)
    else $error("unmapped read not zero");
  free_input_a: assert property (wrK && wdata[1:0] == 2'h3 |-> ##2
    (pinCtl[16].portOe_n && !pinCtl[16].pullUpEn))
    else $error("unpulled input wrong");
  port_drive_a: assert property (wrK && wdata[3:2] == 2'h1 |-> ##2
    (!pinCtl[17].portOe_n && pinCtl[17].mode == pmx_pkg::PMX_OUTPUT))
    else $error("port output not driven");
  pulled_in_a: assert property (wrJ && wdata[1:0] == 2'h2 |-> ##2
    (pinCtl[8].pullUpEn && pinCtl[8].portOe_n))
    else $error("pulled input wrong");
  j_reserved_a: assert property (wrJ && wdata[3:2] == 2'h0 |-> ##2
    (pinCtl[9].reserved && !pinCtl[9].periphSel))
    else $error("port J pin 1 code 00 not reserved");
  l_reserved_a: assert property (wrL && wdata[1:0] == 2'h1 |-> ##2
    (pinCtl[24].reserved && pinCtl[24].portOe_n))
    else $error("reserved code drives pin");
  h7_output_a: assert property (wrH && wdata[15:14] == 2'h1 |-> ##2
    !pinCtl[7].portOe_n)
    else $error("port H pin 7 output not driven");
  strap_in_a: assert property (emulatorModeStrap[*5] |-> strapPortIn)
    else $error("strap not seen as port input");
  strap_low_a: assert property (
    !emulatorModeStrap[*5] |-> !strapPortIn)
    else $error("strap low not seen as port input");

  cover property (wrK ##1 rd);
  cover property (wrL && wdata[1:0] == 2'h1);
  cover property (emulatorModeStrap[*5]);
endmodule

bind pmx_pin_select pmx_pin_select_sva pmx_pin_select_sva_i (
  .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .emulatorModeStrap(emulatorModeStrap),
  .strapPortIn(strapPortIn), .pinCtl(pinCtl));

`default_nettype wire

// ---- tb/testbench.sv ----
// Purpose: self-checking bench for pmx_pin_select
// Assumes: bus strobes one cycle long; pad control two edges after a write
// Notes:   capability masks restated here, not taken from the package
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  logic                       clk, rst_n, wr, rd, strap;
  logic [3:0]                 addr;
  logic [15:0]                wdata;
  logic [15:0]                rdata;
  logic                       strapIn;
  pmx_pkg::pmxPinCtl_t [31:0] pinCtl;
  int                         err_total, checks;
  logic [7:0]                 canPer [4] = '{8'hFF, 8'hCD, 8'hFF, 8'hFF};
  logic [7:0]                 canOut [4] = '{8'h80, 8'hFF, 8'hFF, 8'h00};
  logic [3:0]                 ofs [4] = '{4'h0, 4'h2, 4'h4, 4'h6};

  pmx_pin_select pmx_pin_select_i (.clk(clk), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .emulatorModeStrap(strap), .strapPortIn(strapIn), .pinCtl(pinCtl));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ==========
  // helpers
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 check(rdata, e);
  endtask

  task automatic test_done();
    $display("checks=%0d mismatches=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ==========
  // scenarios
  task automatic t_reset(input logic s);
    @(posedge clk);
    rst_n <= 1'b0;
    strap <= s;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(ofs[0], s ? 16'hAAAA : 16'h8AAA);
    rd_chk(ofs[1], 16'h0000);
    rd_chk(ofs[2], 16'h0000);
    rd_chk(ofs[3], 16'h0000);
    check(pinCtl[6].mode, s ? 16'h0004 : 16'h0001);
    check(pinCtl[0].mode, 16'h0004);
    strap <= ~s;
    repeat (6) @(posedge clk);
    #1 check(strapIn, 16'(!s));
    rd_chk(ofs[0], s ? 16'hAAAA : 16'h8AAA);
    $display("reset test done, strap %b", s);
  endtask

  task automatic t_rw();
    for (int p = 0; p < 4; p++) wr_reg(ofs[p], 16'h5A3C ^ 16'(p));
    wr_reg(4'h8, 16'hFFFF);
    for (int p = 0; p < 4; p++) rd_chk(ofs[p], 16'h5A3C ^ 16'(p));
    rd_chk(4'h9, 16'h0000);
    $display("register access test done");
  endtask

  task automatic t_codes();
    logic [3:0] em;
    logic       res;
    for (int c = 0; c < 4; c++) begin
      for (int p = 0; p < 4; p++) wr_reg(ofs[p], {8{2'(c)}});
      @(posedge clk);
      #1;
      for (int i = 0; i < 32; i++) begin
        case (c)
          0: em = canPer[i/8][i%8] ? 4'h1 : 4'h8;
          1: em = canOut[i/8][i%8] ? 4'h2 : 4'h8;
          2: em = 4'h4;
          default: em = 4'h8;
        endcase
        res = c < 2 && em == 4'h8;
        check(pinCtl[i], {em == 4'h1, em != 4'h2, em == 4'h4, res, em});
      end
      for (int p = 0; p < 4; p++) rd_chk(ofs[p], {8{2'(c)}});
    end
    // converter pins in use: software returns port L to its reset value
    wr_reg(ofs[3], 16'h0000);
    rd_chk(ofs[3], 16'h0000);
    $display("field code test done");
  endtask

  // write strobe followed at once by a read of the same register
  task automatic t_b2b();
    @(posedge clk);
    addr  <= ofs[2];
    wdata <= 16'hC3A5;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    rd    <= 1'b1;
    @(posedge clk);
    rd    <= 1'b0;
    #1 check(rdata, 16'hC3A5);
    $display("back-to-back test done");
  endtask

  initial begin
    repeat (3000) @(posedge clk);
    err_total++;
    test_done();
  end

  initial begin
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 16'h0000;
    strap = 1'b1;
    t_reset(1'b1);
    t_rw();
    t_b2b();
    t_codes();
    t_reset(1'b0);
    test_done();
  end
endmodule

`default_nettype wire
